//--- core/ipc_regs.v
// Interface select and power/gain/current register pair with control decode
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Sleep powers down each block whose sleep-allow mask bit is set.
// - Transmit gate low zeroes data path; high passes data normally.
// - Changing the sync bit from zero to one produces a synchronization event; rewriting a held one does not.
// - Fuse power-down bit set powers down fuses; resets to zero.
// - Mixer gain doubles mixer output only when complex mix enabled.
// - Clock receiver power-down bit powers receiver down regardless of sleep.
// - Clock receiver sleep-allow powers receiver down whenever sleep is invoked.
// - Sleep masks select output stage, clock output and converters.
// - Complex mix only while mix enable set, bypassed otherwise.
module ipc_regs (
    input  wire                     sys_clk,
    input  wire                     rst_n,
    input  wire                     wr_en,
    input  wire [4:0]               wr_addr,
    input  wire [7:0]               wr_data,
    input  wire [4:0]               rd_addr,
    output reg  [7:0]               rd_data,
    input  wire                     ctrl_pin,
    input  wire [2:0]               sleep_allow_masks,
    input  wire                     mix_enable,
    input  wire                     alarm_level,
    input  wire [`IPC_DATA_W-1:0]   chan_a_data,
    input  wire [`IPC_MIX_W-1:0]    mix_in,
    output wire [`IPC_MIX_W-1:0]    chan_a_out,
    output wire                     alarm_sdo_o,
    output wire                     alarm_sdo_oe,
    output wire                     serial_four_wire_select,
    output reg                      sync_pulse,
    output wire                     sleep_active,
    output wire [2:0]               block_power_down,
    output wire                     fuse_power_down,
    output wire                     clock_receiver_power_down,
    output wire [3:0]               coarse_current
);

    ////////////////////////////////////////////////////////////////////////////
    // State and decoded fields
    reg  [7:0] ifsel;
    reg  [7:0] pwr;
    reg  [7:0] next_ifsel;
    reg  [7:0] next_pwr;
    reg        sync_prev;
    reg        next_sync_pulse;
    wire [1:0] pin_sel;
    wire       sleep_eff;
    wire       txgate_eff;
    wire       sync_eff;
    wire       alarm_oe_bit;
    wire       four_wire_bit;
    wire       sleep_bit;
    wire       txgate_bit;
    wire       sync_bit;
    wire       topbit_out_bit;
    wire       fuse_power_down_bit;
    wire       mix_gain_bit;
    wire       clkrx_pd_bit;
    wire       clkrx_allow_bit;
    wire [3:0] coarse_bits;
    wire       out_stage_pd;
    wire       clk_out_pd;
    wire       conv_pd;
    wire       clkrx_sleep_pd;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // One address compare serves both the write strobe and the read mux
    function addr_match;
        input [4:0] addr;
        input [4:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // The pin takes over one control only while the select names it
    function pin_route;
        input [1:0] sel;
        input [1:0] code;
        input       pin_level;
        input       reg_bit;
        begin
            pin_route = (sel == code) ? pin_level : reg_bit;
        end
    endfunction

    // A block sleeps only if its allow bit lets it
    function sleep_gate;
        input sleep;
        input allow;
        begin
            sleep_gate = sleep & allow;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    // Writes to any other address fall through silently
    always @* begin
        next_ifsel = ifsel;
        next_pwr   = pwr;
        if (wr_en && addr_match(wr_addr, `IPC_ADDR_IFSEL)) begin
            next_ifsel = wr_data;
        end
        if (wr_en && addr_match(wr_addr, `IPC_ADDR_PWR)) begin
            next_pwr = wr_data;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ifsel <= `IPC_IFSEL_RESET;
        end else begin
            ifsel <= next_ifsel;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr <= `IPC_PWR_RESET;
        end else begin
            pwr <= next_pwr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads
    always @* begin
        rd_data = `IPC_RD_IDLE;
        if (addr_match(rd_addr, `IPC_ADDR_IFSEL)) begin
            rd_data = ifsel;
        end else if (addr_match(rd_addr, `IPC_ADDR_PWR)) begin
            rd_data = pwr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    // Names only; every field reads straight from its register flop
    assign alarm_oe_bit    = ifsel[`IPC_B_ALARM_OE];
    assign four_wire_bit   = ifsel[`IPC_B_FOUR_WIRE];
    assign sleep_bit       = ifsel[`IPC_B_SLEEP];
    assign txgate_bit      = ifsel[`IPC_B_TXGATE];
    assign sync_bit        = ifsel[`IPC_B_SYNC];
    assign pin_sel         = ifsel[`IPC_B_PINSEL_HI:`IPC_B_PINSEL_LO];
    assign topbit_out_bit  = ifsel[`IPC_B_TOPBIT_OUT];
    assign fuse_power_down_bit     = pwr[`IPC_B_FUSE_POWER_DOWN];
    assign mix_gain_bit    = pwr[`IPC_B_MIX_GAIN];
    assign clkrx_pd_bit    = pwr[`IPC_B_CLKRX_PD];
    assign clkrx_allow_bit = pwr[`IPC_B_CLKRX_ALLOW];
    assign coarse_bits     = pwr[`IPC_B_COARSE_HI:`IPC_B_COARSE_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin routing
    // At most one control follows the pin (none at select 0); the others stay on their bits
    assign sleep_eff  = pin_route(pin_sel, `IPC_PINSEL_SLEEP, ctrl_pin, sleep_bit);
    assign txgate_eff = pin_route(pin_sel, `IPC_PINSEL_TXGATE, ctrl_pin, txgate_bit);
    assign sync_eff   = pin_route(pin_sel, `IPC_PINSEL_SYNC, ctrl_pin, sync_bit);

    ////////////////////////////////////////////////////////////////////////////
    // Sync event
    // Edge, not level: a held one must not resync
    always @* begin
        next_sync_pulse = sync_eff & ~sync_prev;
    end

    // Both reset low, like the sync bit, so reset gives no false edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev  <= 1'b0;
            sync_pulse <= 1'b0;
        end else begin
            sync_prev  <= sync_eff;
            sync_pulse <= next_sync_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power control
    // Masks come from the other power register, so they arrive as inputs
    assign sleep_active = sleep_eff;
    assign out_stage_pd = sleep_gate(sleep_eff, sleep_allow_masks[`IPC_M_OUT]);
    assign clk_out_pd   = sleep_gate(sleep_eff, sleep_allow_masks[`IPC_M_CLK]);
    assign conv_pd      = sleep_gate(sleep_eff, sleep_allow_masks[`IPC_M_CONV]);
    assign block_power_down = {out_stage_pd, clk_out_pd, conv_pd};
    assign fuse_power_down  = fuse_power_down_bit;
    // Direct power-down needs no sleep; either path stops the receiver
    assign clkrx_sleep_pd = sleep_gate(sleep_eff, clkrx_allow_bit);
    assign clock_receiver_power_down = clkrx_pd_bit | clkrx_sleep_pd;
    assign coarse_current = coarse_bits;
    assign serial_four_wire_select = four_wire_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Alarm / serial-out pin
    // The level only reaches the board while the enable drives the pin
    assign alarm_sdo_oe = alarm_oe_bit;
    assign alarm_sdo_o  = topbit_out_bit ? chan_a_data[`IPC_DATA_MSB]
                                         : alarm_level;

    ////////////////////////////////////////////////////////////////////////////
    // Data path
    // Registered so a gate change lands on a clean edge
    ipc_data_gate u_gate (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .tx_gate    (txgate_eff),
        .mix_enable (mix_enable),
        .mix_gain   (mix_gain_bit),
        .mix_in     (mix_in),
        .raw_in     (chan_a_data),
        .data_out   (chan_a_out)
    );

endmodule // ipc_regs
`default_nettype wire

//--- inc/ipc_consts.vh
// Constants for the interface and power control register pair
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH

`define IPC_ADDR_IFSEL        5'h03
`define IPC_ADDR_PWR          5'h04
`define IPC_IFSEL_RESET       8'h10
`define IPC_PWR_RESET         8'h0f

`define IPC_B_ALARM_OE        7
`define IPC_B_FOUR_WIRE       6
`define IPC_B_SLEEP           5
`define IPC_B_TXGATE          4
`define IPC_B_SYNC            3
`define IPC_B_PINSEL_HI       2
`define IPC_B_PINSEL_LO       1
`define IPC_B_TOPBIT_OUT      0

`define IPC_B_FUSE_POWER_DOWN         7
`define IPC_B_MIX_GAIN        6
`define IPC_B_CLKRX_PD        5
`define IPC_B_CLKRX_ALLOW     4
`define IPC_B_COARSE_HI       3
`define IPC_B_COARSE_LO       0

`define IPC_PINSEL_REGS       2'h0
`define IPC_PINSEL_TXGATE     2'h1
`define IPC_PINSEL_SYNC       2'h2
`define IPC_PINSEL_SLEEP      2'h3

`define IPC_DATA_MSB          13
`define IPC_DATA_W            14
`define IPC_MIX_W             16

`define IPC_RD_IDLE           8'h00

`define IPC_M_OUT             2
`define IPC_M_CLK             1
`define IPC_M_CONV            0

`endif

//--- core/ipc_data_gate.v
// Data path gate and mixer gain stage for one channel
`timescale 1ns/1ps
`default_nettype none
`include "ipc_consts.vh"

module ipc_data_gate (
    input  wire                     sys_clk,
    input  wire                     rst_n,
    input  wire                     tx_gate,
    input  wire                     mix_enable,
    input  wire                     mix_gain,
    input  wire [`IPC_MIX_W-1:0]    mix_in,
    input  wire [`IPC_DATA_W-1:0]   raw_in,
    output reg  [`IPC_MIX_W-1:0]    data_out
);

    reg [`IPC_MIX_W-1:0] next_data_out;

    always @* begin
        if (!tx_gate) begin
            next_data_out = {`IPC_MIX_W{1'b0}};
        end else if (mix_enable) begin
            // Doubling wraps; no saturation
            next_data_out = mix_gain ? {mix_in[`IPC_MIX_W-2:0], 1'b0} : mix_in;
        end else begin
            next_data_out = {{(`IPC_MIX_W-`IPC_DATA_W){raw_in[`IPC_DATA_W-1]}}, raw_in};
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= {`IPC_MIX_W{1'b0}};
        end else begin
            data_out <= next_data_out;
        end
    end

endmodule // ipc_data_gate
`default_nettype wire

//--- tb/ipc_props.sv
// Checker for the interface and power register pair
`timescale 1ns/1ps
`default_nettype none
module ipc_props (
    input wire logic        sys_clk, rst_n, wr_en, ctrl_pin, alarm_sdo_o, alarm_sdo_oe,
    input wire logic        sync_pulse, sleep_active, fuse_power_down, clock_receiver_power_down,
    input wire logic [4:0]  wr_addr,
    input wire logic [7:0]  wr_data,
    input wire logic [2:0]  sleep_allow_masks, block_power_down,
    input wire logic [13:0] chan_a_data,
    input wire logic [15:0] chan_a_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Sampled two edges on (three for the registered data path), since register outputs land one edge after the write
    sequence s_if; wr_en && wr_addr == 5'h03; endsequence
    sequence s_pw; wr_en && wr_addr == 5'h04; endsequence
    chk_mask_sleep: assert property (
        block_power_down == (sleep_allow_masks & {3{sleep_active}})) else $error("mask");
    chk_gate_zero: assert property (
        s_if ##0 (!wr_data[4] && wr_data[2:1] == 2'h0) |-> ##3 chan_a_out == 16'h0) else $error("gate");
    chk_sync_once: assert property (sync_pulse |=> !sync_pulse) else $error("sync");
    chk_fuse_power_down: assert property (
        s_pw |-> ##2 fuse_power_down == $past(wr_data[7], 2)) else $error("fuse");
    chk_clkrx_pd: assert property (s_pw |-> ##2 clock_receiver_power_down ==
        ($past(wr_data[5], 2) | ($past(wr_data[4], 2) & sleep_active))) else $error("clkrx");
    chk_alarm_msb: assert property (s_if ##0 (wr_data[7] && wr_data[0]) |->
        ##2 alarm_sdo_oe && alarm_sdo_o == chan_a_data[13]) else $error("alarm");
    chk_pin_sleep: assert property (
        s_if ##0 wr_data[2:1] == 2'h3 |-> ##2 sleep_active == ctrl_pin) else $error("pin");
    chk_reg_sleep: assert property (
        s_if ##0 wr_data[2:1] == 2'h0 |-> ##2 sleep_active == $past(wr_data[5], 2)) else $error("slp");
endmodule // ipc_props
`default_nettype wire

//--- tb/ipc_host_src.sv
// Host side source of channel A samples, mixer output and alarm level
`timescale 1ns/1ps
`default_nettype none
module ipc_host_src (
    input  wire logic [1:0] pick,
    output logic [13:0]     chan_a_data,
    output logic [15:0]     mix_in,
    output logic            alarm_level
);
    // Top bits flip with pick so both pin levels and sign paths are reached
    assign chan_a_data = pick[0] ? 14'h2abc : 14'h1543;
    assign mix_in = pick[1] ? 16'h9234 : 16'h1234;
    assign alarm_level = ~pick[0];
endmodule // ipc_host_src
`default_nettype wire

//--- tb/ipc_regs_test.sv
// Self-checking bench for the interface and power register pair
`timescale 1ns/1ps
`default_nettype none
module ipc_regs_test;
    logic sys_clk = 0, rst_n = 0, wr_en = 0, ctrl_pin = 0, mix_enable = 0, alarm_level;
    logic alarm_sdo_o, alarm_sdo_oe, serial_four_wire_select, sync_pulse, sleep_active;
    logic fuse_power_down, clock_receiver_power_down;
    logic [4:0] wr_addr = 0, rd_addr = 0;
    logic [7:0] wr_data = 0, rd_data;
    logic [2:0] sleep_allow_masks = 3'h5, block_power_down;
    logic [1:0] pick = 0;
    logic [13:0] chan_a_data;
    logic [15:0] mix_in, chan_a_out;
    logic [3:0] coarse_current;
    int bad_count = 0, num_checks = 0, cyc = 0, pulses;
    ipc_regs dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .ctrl_pin(ctrl_pin),
        .sleep_allow_masks(sleep_allow_masks), .mix_enable(mix_enable),
        .alarm_level(alarm_level), .chan_a_data(chan_a_data), .mix_in(mix_in),
        .chan_a_out(chan_a_out), .alarm_sdo_o(alarm_sdo_o), .alarm_sdo_oe(alarm_sdo_oe),
        .serial_four_wire_select(serial_four_wire_select), .sync_pulse(sync_pulse),
        .sleep_active(sleep_active), .block_power_down(block_power_down),
        .fuse_power_down(fuse_power_down),
        .clock_receiver_power_down(clock_receiver_power_down),
        .coarse_current(coarse_current)
    );
    ipc_host_src src (
        .pick(pick), .chan_a_data(chan_a_data), .mix_in(mix_in), .alarm_level(alarm_level)
    );
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin bad_count++; final_report(); end
    end
    task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin bad_count++; $display("[ERR] %s exp %h seen %h", n, exp, seen); end
    endtask
    task automatic tick(); @(posedge sys_clk) #1; endtask
    task automatic wr(logic [4:0] a, logic [7:0] d);
        tick(); wr_en = 1; wr_addr = a; wr_data = d;
        tick(); wr_en = 0;
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] e); rd_addr = a; #1 check("rd", rd_data, e); endtask
    // Sync pulse lands two edges after the write, so four edges cover it
    task automatic syncs(int e);
        pulses = 0;
        repeat (4) begin tick(); pulses += sync_pulse; end
        check("sync", pulses, e);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) tick();
        rst_n = 1;
        rd(5'h03, 8'h10); rd(5'h04, 8'h0f); check("fuse", fuse_power_down, 0);
        wr(5'h1f, 8'hff); rd(5'h1f, 8'h00); rd(5'h05, 8'h00);
        wr(5'h04, 8'ha5); rd(5'h04, 8'ha5); check("coarse", coarse_current, 4'h5);
        check("fuse", fuse_power_down, 1); check("clkrx", clock_receiver_power_down, 1);
        wr(5'h04, 8'h10); check("clkrx", clock_receiver_power_down, 0);
        wr(5'h03, 8'h30); check("clkrx", clock_receiver_power_down, 1);
        check("bpd", block_power_down, 3'h5);
        wr(5'h03, 8'h16); ctrl_pin = 1; tick(); check("slp", sleep_active, 1);
        ctrl_pin = 0; tick(); check("slp", sleep_active, 0); check("bpd", block_power_down, 0);
        wr(5'h03, 8'h02); tick(); tick(); check("data", chan_a_out, 0);
        ctrl_pin = 1; pick = 1; tick(); tick(); check("data", chan_a_out, 16'heabc);
        mix_enable = 1; tick(); tick(); check("data", chan_a_out, 16'h1234);
        wr(5'h04, 8'h4f); tick(); check("data", chan_a_out, 16'h2468);
        wr(5'h03, 8'h18); syncs(1); wr(5'h03, 8'h18); syncs(0);
        wr(5'h03, 8'h10); wr(5'h03, 8'h18); syncs(1);
        ctrl_pin = 0; wr(5'h03, 8'h14); tick(); ctrl_pin = 1; syncs(1);
        wr(5'h03, 8'h91); check("alm", alarm_sdo_o, 1); check("oe", alarm_sdo_oe, 1);
        pick = 2; #1 check("alm", alarm_sdo_o, 0);
        wr(5'h03, 8'h40); check("four", serial_four_wire_select, 1); check("alm", alarm_sdo_o, 1);
        check("oe", alarm_sdo_oe, 0);
        tick(); tick(); check("data", chan_a_out, 0);
        sleep_allow_masks = 3'h2; wr(5'h03, 8'h30);
        check("bpd", block_power_down, 3'h2);
        check("clkrx", clock_receiver_power_down, 0);
        mix_enable = 0; pick = 3; tick(); tick(); check("data", chan_a_out, 16'heabc);
        mix_enable = 1; tick(); tick(); check("data", chan_a_out, 16'h2468);
        rst_n = 0; tick(); rst_n = 1; check("data", chan_a_out, 0); check("sync", sync_pulse, 0);
        rd(5'h03, 8'h10); rd(5'h04, 8'h0f); check("fuse", fuse_power_down, 0);
        final_report();
    end
endmodule // ipc_regs_test
bind ipc_regs ipc_props chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_en(wr_en), .ctrl_pin(ctrl_pin),
    .alarm_sdo_o(alarm_sdo_o), .alarm_sdo_oe(alarm_sdo_oe), .sync_pulse(sync_pulse),
    .sleep_active(sleep_active), .fuse_power_down(fuse_power_down),
    .clock_receiver_power_down(clock_receiver_power_down), .wr_addr(wr_addr),
    .wr_data(wr_data), .sleep_allow_masks(sleep_allow_masks),
    .block_power_down(block_power_down), .chan_a_data(chan_a_data), .chan_a_out(chan_a_out)
);
`default_nettype wire
